// *** core/lpr_pkg.sv ***
// constants and types shared by the light pulse readout
package lpr_pkg;
   // ****************************************
   // clock and integration presets
   // ****************************************
   localparam int MCLK_MHZ = 100;
   localparam int TINT0_US = 64;
   localparam int TINT1_US = 1000;
   localparam int TINT2_US = 16000;
   localparam int TINT3_US = 128000;
   localparam int TINT0_CYC = TINT0_US * MCLK_MHZ;
   localparam int TINT1_CYC = TINT1_US * MCLK_MHZ;
   localparam int TINT2_CYC = TINT2_US * MCLK_MHZ;
   localparam int TINT3_CYC = TINT3_US * MCLK_MHZ;
   localparam int BASE_W = 24;
   localparam int MULT_W = 16;
   localparam int DATA_W = 16;
   // ****************************************
   // serial register map
   // ****************************************
   // device address, value arbitrary
   localparam logic [6:0] DEV_ADDR = 7'h2a;
   localparam logic [7:0] PTR_CTRL = 8'h00;
   localparam logic [7:0] PTR_MULT_HI = 8'h01;
   localparam logic [7:0] PTR_MULT_LO = 8'h02;
   localparam logic [7:0] PTR_DATA_HI = 8'h03;
   localparam logic [7:0] PTR_DATA_LO = 8'h04;
   localparam int CTRL_GAIN_BIT = 0;
   localparam int CTRL_TSEL_LSB = 1;
   localparam int CTRL_STBY_BIT = 3;
   localparam logic [7:0] CTRL_MASK = 8'h0f;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [15:0] MULT_RST = 16'h0001;
   localparam logic [15:0] DATA_RST = 16'h0000;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   typedef enum logic [2:0] {
      LPR_IDLE = 3'b000,
      LPR_ADDR = 3'b001,
      LPR_ACK = 3'b010,
      LPR_WDATA = 3'b011,
      LPR_RDATA = 3'b100,
      LPR_RACK = 3'b101
   } lpr_ser_st_t;
endpackage

// *** core/lpr_sync.sv ***
// two-stage synchroniser for a group of independent levels
`timescale 1ns/100ps
module lpr_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule // lpr_sync

// *** core/lpr_light_readout.sv ***
// light pulse integrating readout: window timer, pulse counter, serial slave
`timescale 1ns/100ps
module lpr_light_readout #(
   parameter logic [lpr_pkg::BASE_W-1:0] TINT0_CYC = 24'(lpr_pkg::TINT0_CYC),
   parameter logic [lpr_pkg::BASE_W-1:0] TINT1_CYC = 24'(lpr_pkg::TINT1_CYC),
   parameter logic [lpr_pkg::BASE_W-1:0] TINT2_CYC = 24'(lpr_pkg::TINT2_CYC),
   parameter logic [lpr_pkg::BASE_W-1:0] TINT3_CYC = 24'(lpr_pkg::TINT3_CYC)
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic link_clk,
   input wire logic light_pulse,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic gain_high,
   output logic standby,
   output logic window_open,
   output logic [lpr_pkg::DATA_W-1:0] illum_data
);
   // ****************************************
   // declarations
   // ****************************************
   logic pulse_s, pulse_d, cfg_tog_s, cfg_tog_d;
   logic [7:0] ctrl_m;
   logic [lpr_pkg::MULT_W-1:0] mult_m, act_mult_m1;
   logic [1:0] act_sel;
   logic [lpr_pkg::BASE_W-1:0] base_cnt, preset;
   logic [lpr_pkg::MULT_W-1:0] mult_cnt;
   logic [lpr_pkg::DATA_W-1:0] cnt, cnt_inc, next_cnt;
   logic res_tog;
   logic pulse_rise, cfg_new, base_end, win_end, restart;
   logic [1:0] cfg_sel;
   logic [lpr_pkg::MULT_W-1:0] cfg_mult_m1;
   logic scl_s, sda_s, res_tog_s, scl_d, sda_d, res_tog_d;
   logic [7:0] ctrl_l, ptr, sh, tx, rd_byte;
   logic [lpr_pkg::MULT_W-1:0] mult_l;
   logic [lpr_pkg::DATA_W-1:0] data_l;
   logic cfg_tog, is_rd, ptr_ph, nack;
   logic [3:0] bitcnt;
   lpr_pkg::lpr_ser_st_t st;
   logic start_c, stop_c, scl_rise, scl_fall, byte_done, wr_en, load_rd;

   // ****************************************
   // measurement domain (mclk)
   // ****************************************
   // pulse input synchronised
   lpr_sync #(.WIDTH(2)) u_msync (
      .clk(mclk),
      .rst_n(rst_n),
      .d({light_pulse, cfg_tog}),
      .q({pulse_s, cfg_tog_s})
   );

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pulse_d <= 1'b0;
         cfg_tog_d <= 1'b0;
      end else begin
         pulse_d <= pulse_s;
         cfg_tog_d <= cfg_tog_s;
      end
   end

   assign pulse_rise = pulse_s & ~pulse_d;
   assign cfg_new = cfg_tog_s ^ cfg_tog_d;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_m <= lpr_pkg::CTRL_RST;
         mult_m <= lpr_pkg::MULT_RST;
      end else if (cfg_new) begin
         ctrl_m <= ctrl_l;
         mult_m <= mult_l;
      end
   end

   assign gain_high = ctrl_m[lpr_pkg::CTRL_GAIN_BIT];
   assign standby = ctrl_m[lpr_pkg::CTRL_STBY_BIT];
   assign cfg_sel = ctrl_m[lpr_pkg::CTRL_TSEL_LSB +: 2];
   assign cfg_mult_m1 = (mult_m == '0) ? '0 : mult_m - 16'h0001;

   assign preset = (act_sel == 2'h0) ? TINT0_CYC :
                   (act_sel == 2'h1) ? TINT1_CYC :
                   (act_sel == 2'h2) ? TINT2_CYC : TINT3_CYC;

   // window ends after preset times multiplier
   assign base_end = (base_cnt == preset - 24'h000001);
   assign win_end = window_open & base_end & (mult_cnt == act_mult_m1);
   assign restart = ~window_open | win_end;

   assign cnt_inc = (cnt == '1) ? cnt : cnt + 16'h0001;
   // one count per pulse in window, held at all ones once full
   assign next_cnt = pulse_rise ? cnt_inc : cnt;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         window_open <= 1'b0;
         act_sel <= 2'h0;
         act_mult_m1 <= '0;
      end else if (standby) begin
         window_open <= 1'b0;
      end else if (restart) begin
         window_open <= 1'b1;
         act_sel <= cfg_sel;
         act_mult_m1 <= cfg_mult_m1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         base_cnt <= '0;
         mult_cnt <= '0;
      end else if (standby || restart) begin
         base_cnt <= '0;
         mult_cnt <= '0;
      end else if (base_end) begin
         base_cnt <= '0;
         mult_cnt <= mult_cnt + 16'h0001;
      end else begin
         base_cnt <= base_cnt + 24'h000001;
      end
   end

   // count pulses, clear at window start
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
      end else if (standby || restart) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end

   // result register loaded at window end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         illum_data <= lpr_pkg::DATA_RST;
         res_tog <= 1'b0;
      end else if (win_end && !standby) begin
         illum_data <= next_cnt;
         res_tog <= ~res_tog;
      end
   end

   // ****************************************
   // serial link domain (link_clk)
   // ****************************************
   // idle bus levels after reset, no false edge
   lpr_sync #(.WIDTH(3), .RST_VAL(3'b110)) u_lsync (
      .clk(link_clk),
      .rst_n(rst_n),
      .d({scl_in, sda_in, res_tog}),
      .q({scl_s, sda_s, res_tog_s})
   );

   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         res_tog_d <= 1'b0;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
         res_tog_d <= res_tog_s;
      end
   end

   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_l <= lpr_pkg::DATA_RST;
      end else if (res_tog_s ^ res_tog_d) begin
         data_l <= illum_data;
      end
   end

   assign start_c = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_c = scl_s & scl_d & ~sda_d & sda_s;
   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   assign byte_done = (bitcnt == lpr_pkg::BITS_PER_BYTE);
   assign wr_en = scl_fall & (st == lpr_pkg::LPR_WDATA) & byte_done & ~ptr_ph;
   assign load_rd = scl_fall & (((st == lpr_pkg::LPR_ACK) & is_rd) |
                                ((st == lpr_pkg::LPR_RACK) & ~nack));
   assign rd_byte = (ptr == lpr_pkg::PTR_CTRL) ? ctrl_l :
                    (ptr == lpr_pkg::PTR_MULT_HI) ? mult_l[15:8] :
                    (ptr == lpr_pkg::PTR_MULT_LO) ? mult_l[7:0] :
                    (ptr == lpr_pkg::PTR_DATA_HI) ? data_l[15:8] :
                    (ptr == lpr_pkg::PTR_DATA_LO) ? data_l[7:0] : 8'h00;
   assign sda_out = 1'b0;

   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_l <= lpr_pkg::CTRL_RST;
         mult_l <= lpr_pkg::MULT_RST;
         cfg_tog <= 1'b0;
      end else if (wr_en) begin
         cfg_tog <= ~cfg_tog;
         if (ptr == lpr_pkg::PTR_CTRL) begin
            ctrl_l <= sh & lpr_pkg::CTRL_MASK;
         end else if (ptr == lpr_pkg::PTR_MULT_HI) begin
            mult_l[15:8] <= sh;
         end else if (ptr == lpr_pkg::PTR_MULT_LO) begin
            mult_l[7:0] <= sh;
         end
      end
   end

   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= lpr_pkg::LPR_IDLE;
         bitcnt <= 4'h0;
         sh <= 8'h00;
         tx <= 8'h00;
         sda_oe <= 1'b0;
         is_rd <= 1'b0;
         ptr_ph <= 1'b0;
         ptr <= 8'h00;
         nack <= 1'b0;
      end else if (start_c) begin
         st <= lpr_pkg::LPR_ADDR;
         bitcnt <= 4'h0;
         sda_oe <= 1'b0;
      end else if (stop_c) begin
         st <= lpr_pkg::LPR_IDLE;
         sda_oe <= 1'b0;
      end else if (scl_rise) begin
         if (st == lpr_pkg::LPR_ADDR || st == lpr_pkg::LPR_WDATA) begin
            sh <= {sh[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
         end
         if (st == lpr_pkg::LPR_RACK) begin
            nack <= sda_s;
         end
      end else if (load_rd) begin
         tx <= {rd_byte[6:0], 1'b0};
         sda_oe <= ~rd_byte[7];
         ptr <= ptr + 8'h01;
         bitcnt <= 4'h1;
         st <= lpr_pkg::LPR_RDATA;
      end else if (scl_fall) begin
         case (st)
            lpr_pkg::LPR_ADDR: begin
               if (byte_done && sh[7:1] == lpr_pkg::DEV_ADDR) begin
                  sda_oe <= 1'b1;
                  is_rd <= sh[0];
                  ptr_ph <= ~sh[0];
                  st <= lpr_pkg::LPR_ACK;
               end else if (byte_done) begin
                  st <= lpr_pkg::LPR_IDLE;
               end
            end
            lpr_pkg::LPR_WDATA: begin
               if (byte_done) begin
                  sda_oe <= 1'b1;
                  ptr_ph <= 1'b0;
                  ptr <= ptr_ph ? sh : ptr + 8'h01;
                  st <= lpr_pkg::LPR_ACK;
               end
            end
            lpr_pkg::LPR_ACK: begin
               sda_oe <= 1'b0;
               bitcnt <= 4'h0;
               st <= lpr_pkg::LPR_WDATA;
            end
            lpr_pkg::LPR_RDATA: begin
               if (byte_done) begin
                  sda_oe <= 1'b0;
                  st <= lpr_pkg::LPR_RACK;
               end else begin
                  sda_oe <= ~tx[7];
                  tx <= {tx[6:0], 1'b0};
                  bitcnt <= bitcnt + 4'h1;
               end
            end
            lpr_pkg::LPR_RACK: begin
               st <= lpr_pkg::LPR_IDLE;
            end
            default: begin
               st <= lpr_pkg::LPR_IDLE;
            end
         endcase
      end
   end
endmodule // lpr_light_readout

// *** tb/lpr_readout_props.sv ***
// port assertions for the light pulse readout
`timescale 1ns/100ps
module lpr_readout_props (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic link_clk,
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic gain_high,
   input wire logic standby,
   input wire logic window_open,
   input wire logic [lpr_pkg::DATA_W-1:0] illum_data
);
   // ****
   // measurement side
   // ****
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   reset_clear_a: assert property (disable iff (1'b0) !rst_n |->
      !window_open && !standby && !gain_high && illum_data == 16'h0000)
      else $error("outputs not cleared in reset");
   standby_shut_a: assert property (standby && $past(standby) |-> !window_open)
      else $error("window open in standby");
   result_hold_a: assert property (!$past(window_open) |-> $stable(illum_data))
      else $error("result changed outside window end");
   restart_a: assert property ($fell(standby) |-> ##[0:1] window_open)
      else $error("no fresh window after standby");
   min_window_a: assert property ($rose(window_open) |=> (window_open || standby)[*7])
      else $error("window closed too early");
   // ****
   // serial side
   // ****
   sda_low_a: assert property (@(posedge link_clk) sda_out == 1'b0)
      else $error("data line value not low");
   ack_low_a: assert property (@(posedge link_clk) disable iff (!rst_n)
      $rose(sda_oe) |-> !scl_in)
      else $error("data driven while clock high");
   bit_hold_a: assert property (@(posedge link_clk) disable iff (!rst_n)
      $rose(scl_in) |=> $stable(sda_oe)[*3])
      else $error("data moved after clock rise");
   win_c: cover property ($rose(window_open));
   stby_c: cover property ($rose(standby));
   ack_c: cover property (@(posedge link_clk) $rose(sda_oe));
endmodule // lpr_readout_props
bind lpr_light_readout lpr_readout_props chk_u (.mclk, .rst_n, .link_clk, .scl_in,
   .sda_out, .sda_oe, .gain_high, .standby, .window_open, .illum_data);

// *** tb/lpr_i2c_ctl.sv ***
// two-wire controller model for the readout serial slave
`timescale 1ns/100ps
module lpr_i2c_ctl #(
   parameter int H = 100
) (
   input wire logic dev_oe,
   output logic scl,
   output wire logic sda
);
   // ****
   // wire, bit, byte and transfer tasks
   // ****
   logic sda_m = 1'b1;
   initial scl = 1'b1;
   assign sda = sda_m & ~dev_oe;
   task automatic start();
      #(H/2) sda_m = 1'b1;
      #(H/2) scl = 1'b1;
      #H sda_m = 1'b0;
      #H scl = 1'b0;
   endtask
   task automatic stop();
      #(H/2) sda_m = 1'b0;
      #(H/2) scl = 1'b1;
      #H sda_m = 1'b1;
      #H;
   endtask
   task automatic bit_x(input logic b, output logic r);
      #(H/2) sda_m = b;
      #(H/2) scl = 1'b1;
      #(H/2) r = sda;
      #(H/2) scl = 1'b0;
   endtask
   task automatic byte_x(input logic [7:0] d, input logic a_in, output logic [7:0] q,
      output logic a);
      for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
      bit_x(a_in, a);
   endtask
   task automatic hdr(input logic [7:0] p, output logic ok);
      logic [7:0] q;
      logic a0, a1;
      start();
      byte_x({lpr_pkg::DEV_ADDR, 1'b0}, 1'b1, q, a0);
      byte_x(p, 1'b1, q, a1);
      ok = !(a0 | a1);
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] v, output logic ok);
      logic [7:0] q;
      logic a;
      hdr(p, ok);
      byte_x(v, 1'b1, q, a);
      stop();
      ok = ok & !a;
   endtask
   task automatic rd(input logic [7:0] p, output logic [7:0] v, output logic ok);
      logic [7:0] q;
      logic a, n;
      hdr(p, ok);
      start();
      byte_x({lpr_pkg::DEV_ADDR, 1'b1}, 1'b1, q, a);
      byte_x(8'hff, 1'b1, v, n);
      stop();
      ok = ok & !a;
   endtask
endmodule // lpr_i2c_ctl

// *** tb/lpr_light_readout_tb.sv ***
// self-checking bench for the light pulse readout
`timescale 1ns/100ps
module lpr_light_readout_tb;
   // ****
   // clocks, design, partner
   // ****
   localparam int TW [4] = '{8, 16, 32, 64};
   localparam logic [15:0] M_EXP = 16'(TW[1] * 3 / 4);
   logic mclk = 1'b0, link_clk = 1'b0, rst_n = 1'b1, light_pulse = 1'b0, pulse_on = 1'b0;
   logic [1:0] pc = 2'h0;
   wire logic scl, sda, sda_out, sda_oe, gain_high, standby, window_open;
   wire logic [15:0] illum_data;
   int fails = 0, checked = 0;
   always #5 mclk = ~mclk;
   initial begin
      #1.3;
      forever #3 link_clk = ~link_clk;
   end
   always @(posedge mclk) begin
      pc <= pc + 2'h1;
      light_pulse <= pulse_on & pc[1];
   end
   lpr_light_readout #(.TINT0_CYC(24'h8), .TINT1_CYC(24'h10), .TINT2_CYC(24'h20),
      .TINT3_CYC(24'h40)) dut_u (.mclk, .rst_n, .link_clk, .light_pulse, .scl_in(scl),
      .sda_in(sda), .sda_out, .sda_oe, .gain_high, .standby, .window_open, .illum_data);
   lpr_i2c_ctl mst_u (.dev_oe(sda_oe), .scl, .sda);
   // ****
   // helpers
   // ****
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      checked++;
      if (s !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic complete_run();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic wait_data(input logic [15:0] e);
      for (int i = 0; i < 3000 && illum_data !== e; i++) @(negedge mclk);
      chk("illum_data", illum_data, e);
   endtask
   task automatic put(input logic [7:0] p, input logic [7:0] v);
      logic ok;
      mst_u.wr(p, v, ok);
      chk("ack", 16'(ok), 16'h0001);
   endtask
   task automatic get(input logic [7:0] p, input logic [7:0] e);
      logic ok;
      logic [7:0] v;
      mst_u.rd(p, v, ok);
      chk("ack", 16'(ok), 16'h0001);
      chk("read", 16'(v), 16'(e));
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_reset();
      @(negedge mclk);
      chk("gain_high", 16'(gain_high), 16'h0000);
      chk("standby", 16'(standby), 16'h0000);
      chk("window_open", 16'(window_open), 16'h0001);
      chk("illum_data", illum_data, 16'h0000);
   endtask
   task automatic t_presets();
      @(posedge mclk) pulse_on <= 1'b1;
      for (int s = 0; s < 4; s++) begin
         put(lpr_pkg::PTR_CTRL, 8'(s * 2 + s % 2));
         chk("gain_high", 16'(gain_high), 16'(s % 2));
         wait_data(16'(TW[s] / 4));
      end
   endtask
   task automatic t_mult();
      put(lpr_pkg::PTR_MULT_HI, 8'h00);
      put(lpr_pkg::PTR_MULT_LO, 8'h03);
      put(lpr_pkg::PTR_CTRL, 8'h02);
      wait_data(M_EXP);
      get(lpr_pkg::PTR_DATA_LO, M_EXP[7:0]);
      get(lpr_pkg::PTR_DATA_HI, M_EXP[15:8]);
      get(lpr_pkg::PTR_MULT_LO, 8'h03);
      get(8'h05, 8'h00);
      get(lpr_pkg::PTR_CTRL, 8'h02);
   endtask
   task automatic t_standby();
      put(lpr_pkg::PTR_CTRL, 8'h0a);
      chk("standby", 16'(standby), 16'h0001);
      chk("window_open", 16'(window_open), 16'h0000);
      @(posedge mclk) pulse_on <= 1'b0;
      repeat (200) @(posedge mclk);
      chk("illum_data", illum_data, M_EXP);
      get(lpr_pkg::PTR_DATA_LO, M_EXP[7:0]);
      put(lpr_pkg::PTR_CTRL, 8'h02);
      chk("window_open", 16'(window_open), 16'h0001);
      wait_data(16'h0000);
   endtask
   initial begin
      #1 rst_n <= 1'b0;
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      t_reset();
      t_presets();
      t_mult();
      t_standby();
      complete_run();
   end
   initial begin
      #200000;
      fails++;
      complete_run();
   end
endmodule // lpr_light_readout_tb
